// >>> rtl/spm_pkg.sv
// Shared constants and types of the serial peripheral port.
// Assumes one 40 MHz core clock; register indices are word indices on AHB-Lite.
package spm_pkg;
   // Register word indices; the byte address is four times the index.
   localparam logic [7:0] CTL_IDX = 8'hbc;
   localparam logic [7:0] STA_IDX = 8'hbd;
   localparam logic [7:0] DAT_IDX = 8'hbe;
   localparam logic [7:0] EVT_IDX = 8'hc0;
   localparam logic [7:0] MSK_IDX = 8'hc1;
   localparam logic [7:0] NO_IDX  = 8'h00;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 9;

   // Control register fields.
   localparam int unsigned CTL_EN    = 7;
   localparam int unsigned CTL_MASTER_SELECT_BIT  = 6;
   localparam int unsigned CTL_CLOCK_IDLE_LEVEL  = 5;
   localparam int unsigned CTL_CLOCK_SAMPLE_EDGE  = 4;
   localparam int unsigned CTL_SELECT_PIN_IGNORE = 3;
   localparam int unsigned CTL_BIT_ORDER_SELECT  = 2;
   localparam int unsigned CTL_RATE  = 0;

   // Status flags sit in bits 7..3; the event and mask registers share that layout.
   localparam int unsigned STA_BUSY = 2;
   localparam int unsigned FLG_LSB  = 3;
   localparam int unsigned F_DONE   = 4;
   localparam int unsigned F_WRITE_COLLISION_FLAG   = 3;
   localparam int unsigned F_MODE_FAULT_FLAG   = 2;
   localparam int unsigned F_OVF    = 1;
   localparam int unsigned F_RFULL  = 0;

   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [4:0] FLG_RST = 5'h00;
   localparam logic [7:0] DAT_RST = 8'h00;
   localparam logic [4:0] EVT_RST = 5'h00;
   localparam logic [4:0] MSK_RST = 5'h00;

   // Sixteen clock edges make one byte.
   localparam logic [4:0] EDGE_LAST = 5'h0f;

   typedef enum logic [2:0] {
      ENG_IDLE = 3'b001,
      ENG_RUN  = 3'b010,
      ENG_DONE = 3'b100
   } spm_eng_t;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ss_n;
   } spm_pin_in_t;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } spm_pin_out_t;

   localparam spm_pin_in_t PIN_IN_RST = '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1};
endpackage : spm_pkg

// >>> rtl/spm_pin_sync.sv
// Two-stage synchroniser for the serial port input pins.
// Assumes the pins are asynchronous to core_clk and change slowly against it.
`timescale 1ns/100ps
module spm_pin_sync
   import spm_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire spm_pkg::spm_pin_in_t pin_i,
   output spm_pkg::spm_pin_in_t      pin_s
);
   typedef struct packed {
      spm_pin_in_t meta;
      spm_pin_in_t sync;
   } spm_sync_st_t;

   localparam spm_sync_st_t SYNC_RST = '{meta: PIN_IN_RST, sync: PIN_IN_RST};

   spm_sync_st_t q;
   spm_sync_st_t n;

   // The first stage feeds only the second one.
   always_comb begin
      n      = q;
      n.meta = pin_i;
      n.sync = q.meta;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= SYNC_RST;
      end else begin
         q <= n;
      end
   end

   assign pin_s = q.sync;
endmodule : spm_pin_sync

// >>> rtl/spm_spi_port.sv
// Byte-wide serial peripheral port, master or slave, with AHB-Lite registers.
// Assumes a 40 MHz core_clk, single word AHB-Lite transfers and slow pins.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps

// What this block does
// [RL1] Clock polarity bit sets idle clock level: low when clear, high when set.
// [RL2] Clock phase bit: sample on first edge when clear, second edge when set.
// [RL3] Transfer-done flag rises when each byte transfer finishes.
// [RL4] Interrupt vectoring or writing zero clears the transfer-done flag.
// [RL5] Writing data while busy raises the write-collision flag.
// [RL6] Write-collision clears by writing zero or by a data write when idle.
// [RL7] Master with select pin honoured: select low raises mode fault; zero clears.
// [RL8] Mode fault clears the enable and master-select control bits.
// [RL9] A finished transfer raises the receive-full flag.
// [RL10] Transfer ending while receive-full is set raises receive-overrun.
// [RL11] Receive-full and overrun clear by writing zero or reading data.
// [RL12] Busy flag stands high for the whole transfer.
// [RL13] Data write when idle loads the shift register; in master mode it starts a transfer.
// [RL14] Reading data returns the receive buffer, not the shift register.
// [RL15] Rate field divides the core clock by 2, 4, 8 or 16.
// [RL16] Enable gates transfers and pin drive; master bit selects role; order bit selects LSB first.
// [RL17] Select-ignore bit set makes the port disregard the select pin.
module spm_spi_port
   import spm_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire spm_pkg::spm_pin_in_t pin_i,
   output spm_pkg::spm_pin_out_t     pin_o,
   input  wire logic                 vector_ack,
   output logic                      irq
);
   typedef struct packed {
      logic [7:0]  ctl;
      logic [4:0]  flg;
      logic [4:0]  evt;
      logic [4:0]  msk;
      spm_eng_t    eng;
      logic [7:0]  rxbuf;
      logic [7:0]  shreg;
      logic        out_bit;
      logic        sck_ph;
      logic        last_sck;
      logic [4:0]  edges;
      logic [3:0]  div;
      logic        dp_wr;
      logic        dp_rd;
      logic        rd_wait;
      logic [7:0]  dp_idx;
      logic [31:0] rdata;
   } spm_state_t;

   localparam spm_state_t STATE_RST = '{ctl: CTL_RST, flg: FLG_RST, evt: EVT_RST, msk: MSK_RST,
                                        eng: ENG_IDLE, rxbuf: DAT_RST, shreg: DAT_RST,
                                        dp_idx: NO_IDX, default: '0};

   function automatic logic tx_bit(input logic [7:0] d, input logic lsb_first);
      tx_bit = lsb_first ? d[0] : d[7];
   endfunction : tx_bit

   function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb_first);
      shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
   endfunction : shift_in

   function automatic logic [3:0] half_lim(input logic [1:0] rate);
      case (rate)
         2'h0:    half_lim = 4'h0;
         2'h1:    half_lim = 4'h1;
         2'h2:    half_lim = 4'h3;
         default: half_lim = 4'h7;
      endcase
   endfunction : half_lim

   function automatic logic [7:0] idx_of(input logic [31:0] a);
      idx_of = (a[31:IDX_MSB+1] == '0 && a[IDX_LSB-1:0] == '0) ? a[IDX_MSB:IDX_LSB] : NO_IDX;
   endfunction : idx_of

   spm_state_t  q;
   spm_state_t  n;
   spm_pin_in_t pin_s;

   logic       en;
   logic       mst;
   logic       clock_idle_level;
   logic       clock_sample_edge;
   logic       select_pin_ignore;
   logic       bit_order_select;
   logic [1:0] rate;
   logic       busy;
   logic       sel;
   logic       aph;
   logic       rd_now;
   logic [7:0] wdat;
   logic       wr_ctl;
   logic       wr_sta;
   logic       wr_dat;
   logic       wr_evt;
   logic       wr_msk;
   logic       rd_dat;
   logic       fault;
   logic       tick;
   logic       edge_ev;
   logic       step;
   logic       fin;
   logic       start;
   logic       in_bit;
   logic [4:0] set_v;
   logic [7:0] rd_val;

   spm_pin_sync u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_i    (pin_i),
      .pin_s    (pin_s)
   );

   assign en    = q.ctl[CTL_EN];
   assign mst   = q.ctl[CTL_MASTER_SELECT_BIT];
   assign clock_idle_level  = q.ctl[CTL_CLOCK_IDLE_LEVEL];
   assign clock_sample_edge  = q.ctl[CTL_CLOCK_SAMPLE_EDGE];
   assign select_pin_ignore = q.ctl[CTL_SELECT_PIN_IGNORE];
   assign bit_order_select  = q.ctl[CTL_BIT_ORDER_SELECT];
   assign rate  = q.ctl[CTL_RATE +: 2];
   // [RL12] busy over transfer
   assign busy  = (q.eng != ENG_IDLE);
   assign fin   = (q.eng == ENG_DONE);
   // [RL17] select pin ignored
   assign sel   = select_pin_ignore || !pin_s.ss_n;
   // [RL7] master select fault
   assign fault = en && mst && !select_pin_ignore && !pin_s.ss_n;

   // Reads take one wait state so that a write in the preceding data phase is seen.
   assign aph    = hsel && htrans[1] && hready;
   assign rd_now = q.dp_rd && q.rd_wait;
   assign wdat   = hwdata[7:0];
   assign wr_ctl = q.dp_wr && q.dp_idx == CTL_IDX;
   assign wr_sta = q.dp_wr && q.dp_idx == STA_IDX;
   assign wr_dat = q.dp_wr && q.dp_idx == DAT_IDX;
   assign wr_evt = q.dp_wr && q.dp_idx == EVT_IDX;
   assign wr_msk = q.dp_wr && q.dp_idx == MSK_IDX;
   assign rd_dat = rd_now && q.dp_idx == DAT_IDX;

   // [RL16] master drives on start
   assign start = wr_dat && !busy && en && mst;

   // [RL15] clock rate divider
   assign tick    = (q.div == half_lim(rate));
   assign edge_ev = mst ? (q.eng == ENG_RUN && tick) : (en && sel && pin_s.sck != q.last_sck);
   assign step    = edge_ev && (q.eng == ENG_RUN || (q.eng == ENG_IDLE && !mst));
   assign in_bit  = mst ? pin_s.miso : pin_s.mosi;

   // [RL3] [RL5] [RL9] [RL10] flag raise events
   assign set_v = {fin, wr_dat && busy, fault, fin && q.flg[F_RFULL], fin};

   always_comb begin
      case (q.dp_idx)
         CTL_IDX: rd_val = q.ctl;
         STA_IDX: rd_val = {q.flg, busy, 2'h0};
         // [RL14] read receive buffer
         DAT_IDX: rd_val = q.rxbuf;
         EVT_IDX: rd_val = {q.evt, 3'h0};
         MSK_IDX: rd_val = {q.msk, 3'h0};
         default: rd_val = 8'h00;
      endcase
   end

   always_comb begin
      n          = q;
      n.last_sck = pin_s.sck;

      if (aph) begin
         n.dp_wr   = hwrite;
         n.dp_rd   = !hwrite;
         n.rd_wait = !hwrite;
         n.dp_idx  = idx_of(haddr);
      end else if (hready) begin
         n.dp_wr = 1'b0;
         n.dp_rd = 1'b0;
      end
      if (rd_now) begin
         n.rdata   = {24'h00_0000, rd_val};
         n.rd_wait = 1'b0;
      end

      if (wr_ctl) begin
         n.ctl = wdat;
      end
      if (wr_msk) begin
         n.msk = wdat[7:FLG_LSB];
      end
      if (wr_evt) begin
         n.evt = q.evt & ~wdat[7:FLG_LSB];
      end
      // [RL4] [RL6] [RL11] zero writes clear
      if (wr_sta) begin
         n.flg = q.flg & wdat[7:FLG_LSB];
      end
      // [RL4] vectoring clears done
      if (vector_ack) begin
         n.flg[F_DONE] = 1'b0;
      end
      // [RL11] data read clears
      if (rd_dat) begin
         n.flg[F_OVF]   = 1'b0;
         n.flg[F_RFULL] = 1'b0;
      end

      // [RL13] load and start
      if (wr_dat && !busy) begin
         n.flg[F_WRITE_COLLISION_FLAG] = 1'b0;
         n.shreg       = wdat;
         n.out_bit     = tx_bit(wdat, bit_order_select);
         if (en && mst) begin
            n.eng   = ENG_RUN;
            n.edges = 5'h00;
            n.sck_ph = 1'b0;
         end
      end

      // [RL15] divider restarts each byte
      n.div = (tick || q.eng != ENG_RUN || !mst) ? 4'h0 : 4'(q.div + 4'h1);

      // [RL2] sample or shift edge
      if (step) begin
         if (q.edges[0] == clock_sample_edge) begin
            n.shreg = shift_in(n.shreg, in_bit, bit_order_select);
         end else begin
            n.out_bit = tx_bit(n.shreg, bit_order_select);
         end
         n.sck_ph = !q.sck_ph;
         n.edges  = 5'(q.edges + 5'h01);
         n.eng    = (q.edges == EDGE_LAST) ? ENG_DONE : ENG_RUN;
      end

      case (q.eng)
         ENG_IDLE: begin
            if (!wr_dat && !step) begin
               n.out_bit = tx_bit(q.shreg, bit_order_select);
            end
         end
         ENG_RUN: begin
            // A slave that loses its select mid-byte drops the partial byte.
            if (!mst && !sel) begin
               n.eng    = ENG_IDLE;
               n.edges  = 5'h00;
               n.sck_ph = 1'b0;
            end
         end
         ENG_DONE: begin
            // [RL9] receive buffer update
            n.rxbuf  = q.shreg;
            n.eng    = ENG_IDLE;
            n.edges  = 5'h00;
            n.sck_ph = 1'b0;
         end
         default: begin
            n.eng = ENG_IDLE;
         end
      endcase

      // [RL16] disable stops activity
      if (!en && q.eng == ENG_RUN) begin
         n.eng    = ENG_IDLE;
         n.edges  = 5'h00;
         n.sck_ph = 1'b0;
      end

      // [RL8] fault drops enable, master
      if (fault) begin
         n.ctl[CTL_EN]   = 1'b0;
         n.ctl[CTL_MASTER_SELECT_BIT] = 1'b0;
         n.eng           = ENG_IDLE;
         n.edges         = 5'h00;
         n.sck_ph        = 1'b0;
      end

      // Hardware sets are applied last so they win over any clear in the same cycle.
      n.flg = n.flg | set_v;
      n.evt = n.evt | set_v;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= STATE_RST;
      end else begin
         q <= n;
      end
   end

   assign hreadyout = !rd_now;
   assign hresp     = 1'b0;
   assign hrdata    = q.rdata;
   assign irq       = |(q.evt & q.msk);

   // [RL1] idle clock level
   assign pin_o.sck_o   = clock_idle_level ^ q.sck_ph;
   assign pin_o.sck_oe  = en && mst;
   assign pin_o.mosi_o  = q.out_bit;
   assign pin_o.mosi_oe = en && mst;
   assign pin_o.miso_o  = q.out_bit;
   assign pin_o.miso_oe = en && !mst && sel;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   chk_idle_sck_level: assert property ( // [RL1]
      q.eng == ENG_IDLE && en && mst |-> pin_o.sck_o == clock_idle_level)
      else $error("master clock not at idle level");

   chk_sample_edge_phase: assert property ( // [RL2]
      step && mst && !fault && q.edges[0] == clock_sample_edge |=> (pin_o.sck_o != clock_idle_level) == !clock_sample_edge)
      else $error("sample taken on wrong clock edge");

   chk_done_flag_raise: assert property ( // [RL3]
      fin |=> q.flg[F_DONE] && q.evt[F_DONE])
      else $error("done flag not raised at end of byte");

   chk_done_vector_clear: assert property ( // [RL4]
      vector_ack && !fin ##1 !fin |-> !q.flg[F_DONE])
      else $error("done flag survived vectoring");

   chk_write_collision_flag_raise: assert property ( // [RL5]
      wr_dat && busy |=> q.flg[F_WRITE_COLLISION_FLAG] && $stable(q.rxbuf) || $past(fin))
      else $error("write collision not flagged");

   chk_write_collision_flag_fresh_clear: assert property ( // [RL6]
      wr_dat && !busy |=> !q.flg[F_WRITE_COLLISION_FLAG])
      else $error("write collision not cleared by idle write");

   chk_fault_raise: assert property ( // [RL7]
      fault |=> q.flg[F_MODE_FAULT_FLAG] && q.eng == ENG_IDLE)
      else $error("mode fault not flagged");

   chk_fault_disables: assert property ( // [RL8]
      $rose(q.flg[F_MODE_FAULT_FLAG]) |-> !q.ctl[CTL_EN] && !q.ctl[CTL_MASTER_SELECT_BIT])
      else $error("mode fault left port enabled");

   chk_rfull_raise: assert property ( // [RL9]
      fin |=> q.flg[F_RFULL] && q.rxbuf == $past(q.shreg))
      else $error("receive buffer not filled");

   chk_overrun_raise: assert property ( // [RL10]
      fin && q.flg[F_RFULL] |=> q.flg[F_OVF])
      else $error("overrun not flagged");

   chk_read_clears: assert property ( // [RL11]
      rd_dat && !fin |=> !q.flg[F_RFULL] && !q.flg[F_OVF])
      else $error("data read did not clear receive flags");

   chk_busy_holds: assert property ( // [RL12]
      start && select_pin_ignore |=> busy [*8] ##1 busy)
      else $error("busy dropped during transfer");

   chk_load_start: assert property ( // [RL13]
      start && !fault |=> q.eng == ENG_RUN && q.shreg == $past(wdat))
      else $error("data write did not load and start");

   chk_read_rxbuf: assert property ( // [RL14]
      rd_now && q.dp_idx == DAT_IDX |=> hreadyout && hrdata == {24'h00_0000, $past(q.rxbuf)})
      else $error("data read did not return receive buffer");

   chk_rate_div4: assert property ( // [RL15]
      mst && q.eng == ENG_RUN && rate == 2'h1 && tick && q.edges < 5'h0e && !fault |=> !tick ##1 tick)
      else $error("clock divide by four wrong");

   chk_disabled_quiet: assert property ( // [RL16]
      !en |=> !busy || $past(fin) || $past(step))
      else $error("disabled port still busy");

   chk_ss_ignored: assert property ( // [RL17]
      en && mst && select_pin_ignore && !q.flg[F_MODE_FAULT_FLAG] && !wr_sta |=> !q.flg[F_MODE_FAULT_FLAG])
      else $error("select pin honoured while ignored");

   cov_master_byte: cover property (fin && mst);
   cov_slave_byte: cover property (fin && !mst);
   cov_mode_fault: cover property (fault);
   cov_overrun: cover property (fin && q.flg[F_RFULL]);
endmodule : spm_spi_port

// >>> dv/spm_far_slave.sv
// Behavioural external serial slave that answers the port while the port is master.
// Assumes the bench hands it the clock mode and bit order that the port is set to.
`timescale 1ns/100ps
module spm_far_slave (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       clock_idle_level,
   input  wire logic       clock_sample_edge,
   input  wire logic       bit_order_select,
   input  wire logic       sel,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   int         obit;
   int         ibit;

   initial begin
      miso = 1'b0;
      rx_q = 8'h00;
   end

   always @(posedge sel) begin
      tx_q = tx_byte;
      obit = 0;
      ibit = 0;
      if (!clock_sample_edge) begin
         miso = bit_order_select ? tx_q[0] : tx_q[7];
         obit = 1;
      end
   end

   always @(sck) begin
      if (sel) begin
         if ((sck ^ clock_idle_level) != clock_sample_edge) begin
            rx_q[bit_order_select ? ibit : 7 - ibit] = mosi;
            ibit++;
         end else if (obit < 8) begin
            miso = bit_order_select ? tx_q[obit] : tx_q[7 - obit];
            obit++;
         end
      end
   end

   // A released line must not keep showing its last bit.
   always @(negedge sel) miso = ~miso;

   assign rx_byte = rx_q;
endmodule : spm_far_slave

// >>> dv/testbench.sv
// Self-checking bench for the serial port: registers over AHB-Lite, master and slave transfers.
// Assumes the far slave model beside it and a 40 MHz core clock.
`timescale 1ns/100ps
module testbench;
   import spm_pkg::*;
   localparam logic [7:0] RIDX [5] = '{CTL_IDX, STA_IDX, DAT_IDX, EVT_IDX, MSK_IDX};
   logic         core_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, vector_ack;
   logic         sck_b, mosi_b, ss_n_b, sel_m, m_clock_idle_level, m_clock_sample_edge, m_bit_order_select, miso_m, sck_prev;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [31:0]  haddr, hwdata, hrdata;
   logic [7:0]   m_tx, m_rx;
   spm_pin_in_t  pin_i;
   spm_pin_out_t pin_o;
   int           err_count, comparisons, gap, last_gap, toggles;

   assign pin_i = '{sck: sck_b, mosi: mosi_b, miso: miso_m, ss_n: ss_n_b};

   spm_spi_port DUT (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hreadyout),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .pin_i     (pin_i),
      .pin_o     (pin_o),
      .vector_ack(vector_ack),
      .irq       (irq)
   );

   spm_far_slave far_dev (
      .sck    (pin_o.sck_o),
      .mosi   (pin_o.mosi_o),
      .clock_idle_level   (m_clock_idle_level),
      .clock_sample_edge   (m_clock_sample_edge),
      .bit_order_select   (m_bit_order_select),
      .sel    (sel_m),
      .tx_byte(m_tx),
      .miso   (miso_m),
      .rx_byte(m_rx)
   );

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Gap is the count of core cycles between the last two serial clock changes.
   always @(posedge core_clk) begin
      sck_prev <= pin_o.sck_o;
      if (pin_o.sck_o !== sck_prev) begin
         last_gap <= gap;
         gap      <= 1;
         toggles  <= toggles + 1;
      end else begin
         gap <= gap + 1;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rdv);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {22'h0, idx, 2'b00};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      bus(1'b1, idx, v, d);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      bus(1'b0, idx, 8'h00, d);
      check(d, {24'h0, exp});
      check(32'(hresp), 32'h0);
   endtask : rdc

   task automatic wait_idle();
      logic [31:0] d;
      do bus(1'b0, STA_IDX, 8'h00, d); while (d[STA_BUSY] !== 1'b0);
   endtask : wait_idle

   task automatic xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] stx);
      int          t0;
      logic [31:0] d;
      {m_clock_idle_level, m_clock_sample_edge, m_bit_order_select} = {c[CTL_CLOCK_IDLE_LEVEL], c[CTL_CLOCK_SAMPLE_EDGE], c[CTL_BIT_ORDER_SELECT]};
      m_tx  = stx;
      wr(CTL_IDX, c);
      repeat (2) @(posedge core_clk);
      // Select the model only once the idle clock level has settled, so a polarity change is no edge.
      sel_m = 1'b1;
      t0 = toggles;
      wr(DAT_IDX, tx);
      bus(1'b0, STA_IDX, 8'h00, d);
      check(32'(d[STA_BUSY]), 32'h1);
      check({30'h0, pin_o.sck_oe, pin_o.mosi_oe}, 32'h3);
      wait_idle();
      check(32'(m_rx), 32'(tx));
      check(32'(toggles - t0), 32'd16);
      check(32'(last_gap), 32'(1 << c[1:0]));
      check(32'(pin_o.sck_o), 32'(c[CTL_CLOCK_IDLE_LEVEL]));
      sel_m = 1'b0;
   endtask : xfer

   task automatic stop_test();
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test

   initial begin
      #1_000_000;
      err_count++;
      stop_test();
   end

   initial begin
      logic [1:0] k;
      logic [7:0] c;
      logic [31:0] d;
      {rst_n, hsel, hwrite, vector_ack, sck_b, mosi_b, sel_m, m_clock_idle_level, m_clock_sample_edge, m_bit_order_select} = '0;
      {ss_n_b, htrans, hsize, haddr, hwdata, m_tx} = {1'b1, 2'b00, 3'b010, 32'h0, 32'h0, 8'h00};
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 5; i++) rdc(RIDX[i], 8'h00);
      wr(8'h10, 8'hff);
      rdc(8'h10, 8'h00);
      wr(STA_IDX, 8'hff);
      rdc(STA_IDX, 8'h00);
      // Every rate, clock mode and bit order; receive data only where the pin sync leaves margin.
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         // Odd modes also set the select-ignore bit, so master bytes run with it both ways.
         c = {2'b11, k, k[0], k[1], k};
         xfer(c, 8'hb1 ^ c, 8'h69 ^ c);
         rdc(STA_IDX, 8'h88);
         bus(1'b0, DAT_IDX, 8'h00, d);
         if (k[1]) check(d, 32'(8'h69 ^ c));
         rdc(STA_IDX, 8'h80);
         wr(STA_IDX, 8'h00);
         rdc(STA_IDX, 8'h00);
      end
      wr(EVT_IDX, 8'hf8);
      c = 8'hc3;
      {m_clock_idle_level, m_clock_sample_edge, m_bit_order_select, m_tx, sel_m} = {3'b000, 8'h5a, 1'b0};
      wr(CTL_IDX, c);
      repeat (2) @(posedge core_clk);
      sel_m = 1'b1;
      wr(DAT_IDX, 8'h11);
      wr(DAT_IDX, 8'h22);
      rdc(STA_IDX, 8'h44);
      wait_idle();
      check(32'(m_rx), 32'h11);
      sel_m = 1'b0;
      xfer(c, 8'h33, 8'h5a);
      rdc(STA_IDX, 8'h98);
      rdc(DAT_IDX, 8'h5a);
      rdc(STA_IDX, 8'h80);
      check(32'(irq), 32'h0);
      wr(MSK_IDX, 8'h80);
      repeat (2) @(posedge core_clk);
      check(32'(irq), 32'h1);
      vector_ack <= 1'b1;
      @(posedge core_clk);
      vector_ack <= 1'b0;
      rdc(STA_IDX, 8'h00);
      wr(EVT_IDX, 8'hf8);
      repeat (2) @(posedge core_clk);
      check(32'(irq), 32'h0);
      wr(CTL_IDX, 8'hc0);
      ss_n_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      rdc(STA_IDX, 8'h20);
      rdc(CTL_IDX, 8'h00);
      wr(STA_IDX, 8'h00);
      rdc(STA_IDX, 8'h00);
      wr(CTL_IDX, 8'hc8);
      repeat (5) @(posedge core_clk);
      rdc(STA_IDX, 8'h00);
      rdc(CTL_IDX, 8'hc8);
      wr(CTL_IDX, 8'h80);
      wr(DAT_IDX, 8'h3c);
      for (int b = 7; b >= 0; b--) begin
         mosi_b <= b[0] ? 1'b0 : 1'b1;
         repeat (4) @(posedge core_clk);
         check({30'h0, pin_o.miso_oe, pin_o.miso_o}, {30'h0, 1'b1, 1'(8'h3c >> b)});
         sck_b <= 1'b1;
         repeat (4) @(posedge core_clk);
         sck_b <= 1'b0;
      end
      wait_idle();
      ss_n_b <= 1'b1;
      rdc(STA_IDX, 8'h88);
      rdc(DAT_IDX, 8'h55);
      stop_test();
   end
endmodule : testbench
